//--- alm_lane_mapper.sv
// sample fifo and lane sample mapper for the two 9-bit 8b/10b link modes
`timescale 1ns/10ps
`include "alm_regs.svh"

// sample fifo with valid and ready on both sides
module alm_fifo #(
  parameter int WIDTH = `ALM_FIFO_W,
  parameter int DEPTH = `ALM_FIFO_D
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop, ready_r, ready_nxt;

  // pointer and count update
  always_comb
  begin
    in_ready  = ready_r;
    out_valid = (cnt_r != '0);
    out_data  = mem_r[rp_r];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_nxt = (cnt_nxt != DEPTH[AW:0]); // registered so ready leaves a flop
  end

  // pointer registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // storage, written only on push
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule // alm_fifo

module alm_lane_mapper (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // configuration
  input  wire logic [3:0]          link_mode_select,
  input  wire alm_pkg::alm_variant_t part_variant,
  // converter samples, channels a to d, one set per beat
  input  wire logic                smp_valid,
  input  wire logic [35:0]         smp_data,
  output logic                     smp_ready,
  // lanes toward the encoders, one octet per lane per beat
  input  wire logic                lane_ready,
  output logic                     lane_valid_r,
  output logic                     lane_frame_start_r,
  output logic [7:0][7:0]          lane_octet_r,
  output logic [7:0]               lane_active_r,
  output logic                     mode_error_r
);
  logic [`ALM_SMP_W-1:0] samp_r [4][20];
  logic [`ALM_SMP_W-1:0] samp_nxt [4][20];
  logic [63:0]           shift_r [8];
  logic [63:0]           shift_nxt [8];
  logic [63:0]           word [8];
  alm_pkg::alm_state_t   st_r, st_nxt;
  alm_pkg::alm_variant_t var_r, var_nxt, cur_var;
  logic [3:0]            mode_r, mode_nxt, cur_mode, oct_r, oct_nxt;
  logic [4:0]            idx_r, idx_nxt, smp_last;
  logic [7:0]            mask;
  logic [7:0][7:0]       octet_nxt;
  logic [7:0]            active_nxt;
  logic                  valid_nxt, start_nxt, err_nxt, mode_ok;
  logic                  f_valid, pop, is_ten;
  logic [35:0]           f_data;

  alm_fifo #(.WIDTH(`ALM_FIFO_W), .DEPTH(`ALM_FIFO_D)) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (smp_valid),
    .in_data   (smp_data),
    .in_ready  (smp_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (pop)
  );

  // mode and variant are taken at the first sample of each frame
  always_comb
  begin
    cur_mode = (st_r == alm_pkg::ALM_ST_COLLECT && idx_r == '0) ?
               link_mode_select : mode_r;
    cur_var  = (st_r == alm_pkg::ALM_ST_COLLECT && idx_r == '0) ?
               part_variant : var_r;
    is_ten   = (cur_mode == `ALM_MODE_TEN);
    mode_ok  = is_ten ||
               (cur_mode == `ALM_MODE_ELEV &&
                cur_var != alm_pkg::ALM_QUAD);
    smp_last = is_ten ? `ALM_SMP_TEN - 5'h01 : `ALM_SMP_ELEV - 5'h01;
    case (cur_var)
      alm_pkg::ALM_SINGLE: mask = is_ten ? `ALM_MASK_2 : `ALM_MASK_4;
      alm_pkg::ALM_DUAL:   mask = is_ten ? `ALM_MASK_4 : `ALM_MASK_8;
      alm_pkg::ALM_QUAD:   mask = is_ten ? `ALM_MASK_8 : 8'h00;
      default:             mask = 8'h00;
    endcase
  end

  // sample store update, kept apart from the sequencer to avoid a loop
  always_comb
  begin
    pop      = (st_r == alm_pkg::ALM_ST_COLLECT) && mode_ok;
    samp_nxt = samp_r;
    if (pop && f_valid)
      for (int c = 0; c < 4; c++)
        samp_nxt[c][idx_r] = f_data[`ALM_SMP_W*c +: `ALM_SMP_W];
  end

  // lane words: mode ten channel = lane/2 split even/odd, mode eleven
  // channel = lane/4 taking every fourth sample, tail in last nibble
  always_comb
  begin
    for (int l = 0; l < 8; l++)
    begin
      word[l] = '0;
      for (int k = 0; k < 5; k++)
      begin
        if (is_ten && k < 4)
          word[l][63-10*k -: 10] = {samp_nxt[l/2][2*k+l%2], 1'b0};
        else if (!is_ten)
          word[l][63-12*k -: 12] = {samp_nxt[l/4][4*k+l%4], 3'b000};
      end
      if (!is_ten)
        word[l][3:0] = `ALM_TAIL;
      if (!mask[l])
        word[l] = '0;
    end
  end

  // frame collection and octet sending
  always_comb
  begin
    st_nxt     = st_r;
    mode_nxt   = cur_mode;
    var_nxt    = cur_var;
    idx_nxt    = idx_r;
    oct_nxt    = oct_r;
    shift_nxt  = shift_r;
    octet_nxt  = lane_octet_r;
    active_nxt = lane_active_r;
    valid_nxt  = 1'b0;
    start_nxt  = 1'b0;
    err_nxt    = !mode_ok;
    case (st_r)
      alm_pkg::ALM_ST_COLLECT:
      begin
        if (pop && f_valid)
        begin
          idx_nxt = idx_r + 5'h01;
          if (idx_r == smp_last)
          begin
            shift_nxt  = word;
            active_nxt = mask;
            idx_nxt    = '0;
            oct_nxt    = '0;
            st_nxt     = alm_pkg::ALM_ST_SEND;
          end
        end
      end
      alm_pkg::ALM_ST_SEND:
      begin
        if (lane_ready)
        begin
          for (int l = 0; l < 8; l++)
          begin
            octet_nxt[l] = shift_r[l][63:56];
            shift_nxt[l] = {shift_r[l][55:0], 8'h00};
          end
          valid_nxt = 1'b1;
          start_nxt = (oct_r == '0);
          oct_nxt   = oct_r + 4'h1;
          if (oct_r == ((mode_r == `ALM_MODE_TEN) ? `ALM_OCT_TEN - 4'h1 :
                        `ALM_OCT_ELEV - 4'h1))
            st_nxt = alm_pkg::ALM_ST_COLLECT;
        end
      end
      default: st_nxt = alm_pkg::ALM_ST_COLLECT;
    endcase
  end

  // registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r               <= alm_pkg::ALM_ST_COLLECT;
      mode_r             <= `ALM_MODE_TEN;
      var_r              <= alm_pkg::ALM_SINGLE;
      idx_r              <= '0;
      oct_r              <= '0;
      lane_valid_r       <= 1'b0;
      lane_frame_start_r <= 1'b0;
      lane_octet_r       <= '0;
      lane_active_r      <= '0;
      mode_error_r       <= 1'b0;
      for (int l = 0; l < 8; l++)
        shift_r[l] <= '0;
      for (int c = 0; c < 4; c++)
        for (int i = 0; i < 20; i++)
          samp_r[c][i] <= '0;
    end
    else
    begin
      st_r               <= st_nxt;
      mode_r             <= mode_nxt;
      var_r              <= var_nxt;
      idx_r              <= idx_nxt;
      oct_r              <= oct_nxt;
      lane_valid_r       <= valid_nxt;
      lane_frame_start_r <= start_nxt;
      lane_octet_r       <= octet_nxt;
      lane_active_r      <= active_nxt;
      mode_error_r       <= err_nxt;
      shift_r            <= shift_nxt;
      samp_r             <= samp_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic load;
  assign load = (st_r == alm_pkg::ALM_ST_COLLECT) && pop && f_valid &&
                (idx_r == smp_last);

  a_ten_lanes: assert property (
    load && is_ten && cur_var == alm_pkg::ALM_SINGLE |=>
      lane_active_r == `ALM_MASK_2 && shift_r[2] == '0 &&
      shift_r[0][63:54] == {samp_r[0][0], 1'b0} &&
      shift_r[1][53:44] == {samp_r[0][3], 1'b0})
    else $error("mode ten lane packing wrong");
  a_elev_quad: assert property (
    cur_mode == `ALM_MODE_ELEV && cur_var == alm_pkg::ALM_QUAD &&
    st_r == alm_pkg::ALM_ST_COLLECT |-> !pop ##1 mode_error_r)
    else $error("mode eleven accepted on quad part");
  a_elev_tail: assert property (
    load && !is_ten |=> shift_r[0][3:0] == `ALM_TAIL &&
      shift_r[3][51:40] == {samp_r[0][7], 3'b000})
    else $error("mode eleven packing wrong");
  a_lane2_even: assert property (
    load && is_ten && cur_var != alm_pkg::ALM_SINGLE |=>
      shift_r[2][43:34] == {samp_r[1][4], 1'b0})
    else $error("lane 2 not even second channel");
  a_lane3_odd: assert property (
    load && is_ten && cur_var != alm_pkg::ALM_SINGLE |=>
      shift_r[3][33:24] == {samp_r[1][7], 1'b0})
    else $error("lane 3 not odd second channel");
  a_lane_owner: assert property (
    load && !is_ten && cur_var == alm_pkg::ALM_DUAL |=>
      shift_r[4][63:52] == {samp_r[1][0], 3'b000} &&
      shift_r[7][15:4] == {samp_r[1][19], 3'b000})
    else $error("mode eleven second channel lanes wrong");
endmodule // alm_lane_mapper

//--- alm_regs.svh
// constants of the lane sample mapper
`ifndef ALM_REGS_SVH
`define ALM_REGS_SVH
`define ALM_SMP_W      9
`define ALM_FIFO_W     36
`define ALM_FIFO_D     32
`define ALM_MODE_TEN   4'hA
`define ALM_MODE_ELEV  4'hB
`define ALM_SMP_TEN    5'h08
`define ALM_SMP_ELEV   5'h14
`define ALM_OCT_TEN    4'h5
`define ALM_OCT_ELEV   4'h8
`define ALM_TAIL       4'h0
`define ALM_MASK_2     8'h03
`define ALM_MASK_4     8'h0F
`define ALM_MASK_8     8'hFF
`endif

//--- alm_pkg.sv
// types of the lane sample mapper
package alm_pkg;
  typedef enum logic [1:0] {
    ALM_SINGLE = 2'b00,
    ALM_DUAL   = 2'b01,
    ALM_QUAD   = 2'b10
  } alm_variant_t;
  typedef enum logic {
    ALM_ST_COLLECT = 1'b0,
    ALM_ST_SEND    = 1'b1
  } alm_state_t;
endpackage

//--- alm_lane_sink.sv
// lane receiver model that paces the lane ready handshake
`timescale 1ns/10ps
module alm_lane_sink (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // pacing from the bench
  input  wire logic hold,
  input  wire logic slow,
  // lane handshake
  output logic      lane_ready
);
  int seed = 4321;
  // ready stays low while hold is set, drops at random when slow
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lane_ready <= 1'h0;
    else
      lane_ready <= !hold && (!slow || ($random(seed) & 1) == 0);
  end
endmodule // alm_lane_sink

//--- alm_lane_mapper_tb.sv
// self-checking bench of the lane sample mapper
`timescale 1ns/10ps
`include "alm_regs.svh"
module alm_lane_mapper_tb;
  logic                  sys_clk, rst, smp_valid, smp_ready;
  logic                  lane_ready, lane_valid_r, lane_frame_start_r;
  logic                  mode_error_r, hold, slow, ten;
  logic [3:0]            link_mode_select;
  alm_pkg::alm_variant_t part_variant;
  logic [35:0]           smp_data, sq[$], fr[20];
  logic [7:0][7:0]       lane_octet_r;
  logic [7:0]            lane_active_r;
  logic [63:0]           got[8];
  int                    err_count, samples_checked, seed, cyc, vr;
  int                    frames, refused, ocnt;

  alm_lane_mapper u_alm_lane_mapper (.sys_clk(sys_clk), .rst(rst),
    .link_mode_select(link_mode_select), .part_variant(part_variant),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .lane_ready(lane_ready), .lane_valid_r(lane_valid_r),
    .lane_frame_start_r(lane_frame_start_r), .lane_octet_r(lane_octet_r),
    .lane_active_r(lane_active_r), .mode_error_r(mode_error_r));
  alm_lane_sink u_alm_lane_sink (.sys_clk(sys_clk), .rst(rst),
    .hold(hold), .slow(slow), .lane_ready(lane_ready));

  // clock
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task err(input string msg);
    err_count++;
    $display("ERROR %0t: %s", $time, msg);
  endtask

  task summarize;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic int nlanes;
    return (ten ? 2 : 4) << vr;
  endfunction

  // expected lane word, first sample in the upper bits
  function automatic logic [63:0] exp_word(input int l);
    logic [63:0] w;
    int          c;
    w = '0;
    c = ten ? l / 2 : l / 4;
    if (l < nlanes())
      for (int k = 0; k < (ten ? 4 : 5); k++)
        if (ten)
          w = {w[53:0], fr[2 * k + l % 2][c * 9 +: 9], 1'h0};
        else
          w = {w[51:0], fr[4 * k + l % 4][c * 9 +: 9], 3'h0};
    if (!ten)
      w = {w[59:0], 4'h0};
    return w;
  endfunction

  function automatic logic [35:0] rnd;
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[35:0];
  endfunction

  task cfg(input logic t, input int v);
    @(posedge sys_clk);
    link_mode_select <= t ? `ALM_MODE_TEN : `ALM_MODE_ELEV;
    part_variant <= alm_pkg::alm_variant_t'(v[1:0]);
    ten = t;
    vr = v;
  endtask

  task put(input logic [35:0] d);
    smp_valid <= 1'h1;
    smp_data <= d;
    @(negedge sys_clk);
    while (smp_ready !== 1'h1)
    begin
      refused++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    sq.push_back(d);
  endtask

  task send(input int n);
    int nf;
    nf = frames + n / (ten ? 8 : 20);
    for (int i = 0; i < n; i++)
      put(i == 0 ? 36'hF_FFFF_FFFF : i == 1 ? 36'h0 : rnd());
    smp_valid <= 1'h0;
    while (frames < nf)
      @(posedge sys_clk);
  endtask

  task bad(input logic [3:0] m, input int v);
    @(posedge sys_clk);
    rst <= 1'h1;
    link_mode_select <= m;
    part_variant <= alm_pkg::alm_variant_t'(v[1:0]);
    @(posedge sys_clk);
    rst <= 1'h0;
    smp_valid <= 1'h1;
    repeat (40) @(posedge sys_clk);
    smp_valid <= 1'h0;
    @(negedge sys_clk);
    samples_checked++;
    if (mode_error_r !== 1'h1 || smp_ready !== 1'h0) err("bad mode");
  endtask

  // collect octets per lane and compare each finished frame
  always @(posedge sys_clk)
  begin
    if (lane_valid_r === 1'h1)
    begin
      for (int l = 0; l < 8; l++)
        got[l] = {got[l][55:0], lane_octet_r[l]};
      ocnt++;
      samples_checked++;
      if (lane_frame_start_r !== (ocnt == 1)) err("start");
      if (mode_error_r !== 1'h0) err("mode flag");
      if (lane_active_r !== 8'hFF >> (8 - nlanes())) err("lanes");
      if (ocnt == (ten ? 5 : 8))
      begin
        for (int i = 0; i < (ten ? 8 : 20); i++)
          fr[i] = sq.pop_front();
        for (int l = 0; l < 8; l++)
        begin
          samples_checked++;
          if ((ten ? {24'h0, got[l][39:0]} : got[l]) !== exp_word(l)) err("word");
        end
        frames++;
        ocnt = 0;
      end
    end
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err("timeout");
      summarize();
    end
  end

  // main sequence
  initial
  begin
    seed = 55569;
    rst = 1'h1;
    smp_valid = 1'h0;
    smp_data = '0;
    link_mode_select = `ALM_MODE_TEN;
    part_variant = alm_pkg::ALM_SINGLE;
    hold = 1'h0;
    slow = 1'h0;
    ten = 1'h1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    for (int m = 0; m < 5; m++)
    begin
      cfg(m < 3, m < 3 ? m : m - 3);
      for (int f = 0; f < 2; f++)
      begin
        slow <= f[0];
        send(m < 3 ? 16 : 40);
      end
    end
    cfg(1'h1, 2);
    hold <= 1'h1;
    refused = 0;
    fork
      send(48);
      begin
        wait (refused > 0);
        samples_checked++;
        // one frame held in the mapper plus a full fifo
        if (sq.size() != 40) err("fifo depth");
        @(posedge sys_clk);
        hold <= 1'h0;
      end
    join
    @(negedge sys_clk);
    samples_checked++;
    if (smp_ready !== 1'h1) err("drain");
    bad(`ALM_MODE_ELEV, 2);
    bad(4'h3, 0);
    summarize();
  end
endmodule // alm_lane_mapper_tb
